// file: verilog/cspoc_pkg.sv
package cspoc_pkg;
	// wishbone register byte offsets
	localparam logic [7:0] OFS_FUNC     = 8'h00;
	localparam logic [7:0] OFS_FIRST_SETPOINT     = 8'h04;
	localparam logic [7:0] OFS_SECOND_SETPOINT     = 8'h08;
	localparam logic [7:0] OFS_OFFSET   = 8'h0c;
	localparam logic [7:0] OFS_PULSE1   = 8'h10;
	localparam logic [7:0] OFS_PULSE2   = 8'h14;
	localparam logic [7:0] OFS_COUNT    = 8'h18;
	localparam logic [7:0] OFS_DISPLAY  = 8'h1c;
	localparam logic [7:0] OFS_STATUS   = 8'h20;
	// status field positions
	localparam int ST_OUT1 = 0;
	localparam int ST_OUT2 = 1;
	localparam int ST_RUN  = 2;
	localparam int ST_HOLD = 3;
	// widths and reset values
	localparam int CNT_W = 32;
	localparam int PT_W  = 20;
	localparam logic [3:0] FUNC_RESET = 4'h1;
	// output function codes
	localparam logic [3:0] F_MR1  = 4'h1;
	localparam logic [3:0] F_MR2  = 4'h2;
	localparam logic [3:0] F_MR3  = 4'h3;
	localparam logic [3:0] F_MR4  = 4'h4;
	localparam logic [3:0] F_MR5  = 4'h5;
	localparam logic [3:0] F_MR6  = 4'h6;
	localparam logic [3:0] F_MR7  = 4'h7;
	localparam logic [3:0] F_AR_CLR  = 4'h8;
	localparam logic [3:0] F_AR_RLD  = 4'h9;
	localparam logic [3:0] F_AR_STP  = 4'ha;
	localparam logic [3:0] F_AR_STRL = 4'hb;
	localparam logic [3:0] F_AR_DHC  = 4'hc;
	localparam logic [3:0] F_AR_DHR  = 4'hd;
	localparam logic [3:0] F_AR_CPZ  = 4'he;
	// timing: pulse units are 10 ms ticks
	localparam int CLK_MHZ   = 250;
	localparam int TICK_MS   = 10;
	localparam int TICK_CYC  = TICK_MS * 1000 * CLK_MHZ;
endpackage

// file: verilog/cspoc_top.sv
`timescale 1ns/1ps
// Behaviour
// [RQ1] count equal to first setpoint asserts output 1 in every function
// [RQ2] nonzero output-1 pulse time drops output 1 when it elapses
// [RQ3] zero output-1 pulse time latches until manual reset or output 2
// [RQ4] manual functions: second setpoint asserts output 2, counting goes on
// [RQ5] output-2 pulse end drops output 2 and output 1 together
// [RQ6] manual reset loads count with reset offset
// [RQ7] function 4 ignores pulse times, output 2 latches until manual reset
// [RQ8] function 5 latches both until manual reset or count equals offset
// [RQ9] function 6: output 1 pulses or latches, output 2 as function 5
// [RQ10] function 7: output 2 latches if pulse zero, else drops at end
// [RQ11] clearing auto reset: second setpoint asserts output 2, clears count
// [RQ12] reloading auto reset: load second setpoint, keep counting
// [RQ13] stopping auto reset halts; pulse end clears count and drops output 2
// [RQ14] stop-reload: pulse end reloads second setpoint, restarts, drops out 2
// [RQ15] display hold clear: display shows second setpoint until pulse end
// [RQ16] display hold reload: reload and continue, display held to pulse end
// [RQ17] continue past zero: pulse end clears count and drops output 2
// [RQ18] pulse time in hundredths of a second, zero means indefinite
// [RQ19] output function register resets to selection 1
// [RQ20] setpoints compared every clock the count changes
// [RQ21] pulse timers run on 10 ms tick, restart on activation, stop on reset
module cspoc_top #(
	// tick length is open so a bench can shrink the 10 ms pulse unit
	parameter int TICK_CYC = cspoc_pkg::TICK_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        count_up_pin,
	input  wire logic        count_dn_pin,
	input  wire logic        manual_reset_pin,
	output logic             out1,
	output logic             out2
);
	localparam int TW = $clog2(TICK_CYC + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
	localparam int CW = cspoc_pkg::CNT_W;
	localparam int PW = cspoc_pkg::PT_W;

	logic [3:0]    func;
	logic [CW-1:0] first_setpoint, second_setpoint, reset_offset, count;
	logic [PW-1:0] pulse1, pulse2, tmr1, tmr2;
	logic          run, hold;
	logic [TW-1:0] presc;
	logic [2:0]    sync_up, sync_dn, sync_mr;
	logic          mr_prev;

	// pins cross in through two flops; edge detect compares the second with its one-clock-delayed copy
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_up <= 3'h0;
			sync_dn <= 3'h0;
			sync_mr <= 3'h0;
			mr_prev <= 1'b0;
		end else begin
			sync_up <= {sync_up[1:0], count_up_pin};
			sync_dn <= {sync_dn[1:0], count_dn_pin};
			sync_mr <= {sync_mr[1:0], manual_reset_pin};
			mr_prev <= sync_mr[1];
		end
	end
	wire up_ev = sync_up[1] & ~sync_up[2];
	wire dn_ev = sync_dn[1] & ~sync_dn[2];
	wire mr_lvl = sync_mr[1];
	wire mr_ev = mr_lvl & ~mr_prev;

	// 10 ms prescaler
	wire tick = (presc == TICK_LAST); // RQ21
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			presc <= '0;
		else
			presc <= tick ? '0 : presc + TW'(1);
	end

	// function classes
	wire f_manual = (func <= cspoc_pkg::F_MR7);
	wire f_nopulse = (func == cspoc_pkg::F_MR4) ||
		(func == cspoc_pkg::F_MR5);
	wire p1_used = !f_nopulse && (pulse1 != '0); // RQ2 RQ7 RQ8
	wire p2_used = (pulse2 != '0) && (func == cspoc_pkg::F_MR2 ||
		func == cspoc_pkg::F_MR3 || func == cspoc_pkg::F_MR7 ||
		!f_manual); // RQ7 RQ9 RQ10
	wire f_latch_off = (func == cspoc_pkg::F_MR5) ||
		(func == cspoc_pkg::F_MR6);

	// count step; comparison is made on the value being entered
	wire step = run & (up_ev ^ dn_ev);
	wire [CW-1:0] stepped = up_ev ? count + CW'(1) : count - CW'(1);
	wire hit1 = step && (stepped == first_setpoint); // RQ1 RQ20
	wire hit2 = step && (stepped == second_setpoint); // RQ4 RQ20
	wire at_off = step && (stepped == reset_offset); // RQ8
	// a new hit reloads its timer and wins over a pulse end in that cycle
	wire end1 = out1 && p1_used && tick && (tmr1 == PW'(1)) &&
		!hit1; // RQ2
	wire end2 = out2 && p2_used && tick && (tmr2 == PW'(1)) &&
		!hit2; // RQ5

	logic [CW-1:0] next_count;
	logic          next_run, next_out1, next_out2, next_hold;
	always_comb begin
		next_count = step ? stepped : count;
		next_run = run;
		next_hold = hold;
		next_out1 = out1;
		next_out2 = out2;
		if (hit1)
			next_out1 = 1'b1; // RQ1
		if (end1)
			next_out1 = 1'b0; // RQ2
		if (hit2) begin
			next_out2 = 1'b1; // RQ4
			case (func)
				cspoc_pkg::F_AR_CLR: next_count = '0; // RQ11
				cspoc_pkg::F_AR_RLD: next_count = second_setpoint; // RQ12
				cspoc_pkg::F_AR_STP, cspoc_pkg::F_AR_STRL: begin
					next_run = 1'b0; // RQ13
				end
				cspoc_pkg::F_AR_DHC: begin
					next_count = '0; // RQ15
					next_hold = 1'b1;
				end
				cspoc_pkg::F_AR_DHR: begin
					next_count = second_setpoint; // RQ16
					next_hold = 1'b1;
				end
				default: next_count = stepped; // RQ17
			endcase
		end
		if (end2) begin
			next_out2 = 1'b0; // RQ5
			next_out1 = hit1; // RQ5
			next_hold = 1'b0; // RQ15 RQ16
			case (func)
				cspoc_pkg::F_AR_STP, cspoc_pkg::F_AR_CPZ: begin
					next_count = '0; // RQ13 RQ17
					next_run = 1'b1;
				end
				cspoc_pkg::F_AR_STRL: begin
					next_count = second_setpoint; // RQ14
					next_run = 1'b1;
				end
				default: ;
			endcase
		end
		if (f_latch_off && at_off && !hit1 && !hit2) begin
			next_out1 = (func == cspoc_pkg::F_MR6) ? out1 : 1'b0; // RQ8
			next_out2 = 1'b0; // RQ8 RQ9
		end
		if (mr_ev) begin
			next_count = reset_offset; // RQ6
			next_run = 1'b1;
			next_hold = 1'b0;
			next_out1 = 1'b0; // RQ3
			next_out2 = 1'b0; // RQ7 RQ10
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			run <= 1'b1;
			hold <= 1'b0;
			out1 <= 1'b0;
			out2 <= 1'b0;
		end else begin
			count <= next_count;
			run <= next_run;
			hold <= next_hold;
			out1 <= next_out1;
			out2 <= next_out2;
		end
	end

	// pulse timers count down in 10 ms ticks from the programmed value
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tmr1 <= '0;
			tmr2 <= '0;
		end else begin
			if (mr_ev)
				tmr1 <= '0; // RQ21
			else if (hit1)
				tmr1 <= pulse1; // RQ21 RQ18
			else if (tick && tmr1 != '0)
				tmr1 <= tmr1 - PW'(1);
			if (mr_ev)
				tmr2 <= '0; // RQ21
			else if (hit2)
				tmr2 <= pulse2; // RQ21 RQ18
			else if (tick && tmr2 != '0)
				tmr2 <= tmr2 - PW'(1);
		end
	end

	// wishbone slave: ack one cycle after request, dropped the next
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i & (&wb_sel_i);
	logic [31:0] rd_mux;
	always_comb begin
		case (wb_adr_i)
			cspoc_pkg::OFS_FUNC:    rd_mux = {28'h0, func};
			cspoc_pkg::OFS_FIRST_SETPOINT:    rd_mux = first_setpoint;
			cspoc_pkg::OFS_SECOND_SETPOINT:    rd_mux = second_setpoint;
			cspoc_pkg::OFS_OFFSET:  rd_mux = reset_offset;
			cspoc_pkg::OFS_PULSE1:  rd_mux = {12'h0, pulse1};
			cspoc_pkg::OFS_PULSE2:  rd_mux = {12'h0, pulse2};
			cspoc_pkg::OFS_COUNT:   rd_mux = count;
			cspoc_pkg::OFS_DISPLAY: rd_mux = hold ? second_setpoint : count;
			cspoc_pkg::OFS_STATUS:  rd_mux = {28'h0, hold, run, out2, out1};
			default:                rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			func <= cspoc_pkg::FUNC_RESET; // RQ19
			first_setpoint <= '0;
			second_setpoint <= '0;
			reset_offset <= '0;
			pulse1 <= '0;
			pulse2 <= '0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_mux : 32'h0;
			if (wr) begin
				case (wb_adr_i)
					cspoc_pkg::OFS_FUNC:   func <= wb_dat_i[3:0]; // RQ19
					cspoc_pkg::OFS_FIRST_SETPOINT:   first_setpoint <= wb_dat_i;
					cspoc_pkg::OFS_SECOND_SETPOINT:   second_setpoint <= wb_dat_i;
					cspoc_pkg::OFS_OFFSET: reset_offset <= wb_dat_i;
					cspoc_pkg::OFS_PULSE1: pulse1 <= wb_dat_i[PW-1:0];
					cspoc_pkg::OFS_PULSE2: pulse2 <= wb_dat_i[PW-1:0];
					default: ;
				endcase
			end
		end
	end

	a_out1_on_hit: assert property ( // RQ1
		@(posedge mclk) disable iff (!rst_n)
		hit1 && !mr_ev && !(end2) |=> out1)
		else $error("output 1 not set at first setpoint");
	a_mr_loads: assert property ( // RQ6
		@(posedge mclk) disable iff (!rst_n)
		mr_ev |=> count == $past(reset_offset) && !out1 && !out2)
		else $error("manual reset did not load offset");
	a_end2_both: assert property ( // RQ5
		@(posedge mclk) disable iff (!rst_n)
		end2 && !hit2 && !hit1 |=> !out2 && !out1)
		else $error("pulse end left an output on");
	a_clr_count: assert property ( // RQ11
		@(posedge mclk) disable iff (!rst_n)
		hit2 && !mr_ev && func == cspoc_pkg::F_AR_CLR |=>
		count == '0 && out2)
		else $error("clearing function did not clear");
	a_rld_count: assert property ( // RQ12
		@(posedge mclk) disable iff (!rst_n)
		hit2 && !mr_ev && func == cspoc_pkg::F_AR_RLD |=>
		count == $past(second_setpoint))
		else $error("reload function did not reload");
	a_stop_halts: assert property ( // RQ13
		@(posedge mclk) disable iff (!rst_n)
		hit2 && !mr_ev && func == cspoc_pkg::F_AR_STP |=> !run)
		else $error("stopping function kept counting");
	a_f4_latch: assert property ( // RQ7
		@(posedge mclk) disable iff (!rst_n)
		func == cspoc_pkg::F_MR4 && out2 && !mr_ev && $stable(func)
		|=> out2)
		else $error("function 4 output 2 dropped");
	a_tmr_load: assert property ( // RQ21
		@(posedge mclk) disable iff (!rst_n)
		hit1 && !mr_ev |=> tmr1 == $past(pulse1))
		else $error("pulse timer not restarted");
	a_func_reset: assert property ( // RQ19
		@(posedge mclk) $rose(rst_n) |-> func == cspoc_pkg::FUNC_RESET)
		else $error("function not reset to default");
	a_end1_drops: assert property ( // RQ2
		@(posedge mclk) disable iff (!rst_n)
		end1 && !mr_ev |=> !out1)
		else $error("output 1 stayed on after its pulse");
	a_stop_end: assert property ( // RQ13
		@(posedge mclk) disable iff (!rst_n)
		end2 && !mr_ev && func == cspoc_pkg::F_AR_STP |=>
		count == '0 && run && !out2)
		else $error("stopping function pulse end wrong");
	a_strl_end: assert property ( // RQ14
		@(posedge mclk) disable iff (!rst_n)
		end2 && !mr_ev && func == cspoc_pkg::F_AR_STRL |=>
		count == $past(second_setpoint) && run && !out2)
		else $error("stop-reload pulse end wrong");
	a_hold_set: assert property ( // RQ15
		@(posedge mclk) disable iff (!rst_n)
		hit2 && !mr_ev && func == cspoc_pkg::F_AR_DHC |=>
		hold && count == '0)
		else $error("display hold not entered");
	a_hold_clear: assert property ( // RQ16
		@(posedge mclk) disable iff (!rst_n)
		end2 && !mr_ev |=> !hold)
		else $error("display hold kept after pulse end");
	a_f5_offset: assert property ( // RQ8
		@(posedge mclk) disable iff (!rst_n)
		func == cspoc_pkg::F_MR5 && at_off && !hit1 && !hit2 && !mr_ev
		|=> !out1 && !out2)
		else $error("function 5 outputs kept at offset");
	a_tmr_stop: assert property ( // RQ21
		@(posedge mclk) disable iff (!rst_n)
		mr_ev |=> tmr1 == '0 && tmr2 == '0)
		else $error("pulse timers not stopped by manual reset");
	c_hit1: cover property (@(posedge mclk) disable iff (!rst_n) hit1);
	c_end2: cover property (@(posedge mclk) disable iff (!rst_n) end2);
	c_mr: cover property (@(posedge mclk) disable iff (!rst_n) mr_ev);
	c_end1: cover property (@(posedge mclk) disable iff (!rst_n) end1);
	c_hold: cover property (@(posedge mclk) disable iff (!rst_n) hold);
endmodule // cspoc_top

// file: sim/cspoc_relay_model.sv
`timescale 1ns/1ps
// far side: encoder pulse source and the manual reset push-button
module cspoc_relay_model (
	input  wire logic mclk,
	output logic      count_up_pin,
	output logic      count_dn_pin,
	output logic      manual_reset_pin
);
	// cycles each pin level is held; raised by the bench for a slow source
	int gap = 4;

	initial begin
		count_up_pin = 1'b0;
		count_dn_pin = 1'b0;
		manual_reset_pin = 1'b0;
	end

	// levels held for several clocks so the two-flop synchroniser sees them
	task automatic step(input bit up, input int n);
		repeat (n) begin
			@(posedge mclk);
			if (up)
				count_up_pin <= 1'b1;
			else
				count_dn_pin <= 1'b1;
			repeat (gap) @(posedge mclk);
			count_up_pin <= 1'b0;
			count_dn_pin <= 1'b0;
			repeat (gap) @(posedge mclk);
		end
	endtask

	task automatic press_reset();
		@(posedge mclk);
		manual_reset_pin <= 1'b1;
		repeat (gap) @(posedge mclk);
		manual_reset_pin <= 1'b0;
		repeat (gap) @(posedge mclk);
	endtask
endmodule // cspoc_relay_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
	logic        mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        up, dn, mr, out1, out2;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	int          err_count, cmp_count, cyc_count;
	// tick shortened so pulse ends are reached within the run
	localparam int TICK_T = 10;

	cspoc_top #(.TICK_CYC(TICK_T)) u_cspoc_top (.mclk(mclk), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .count_up_pin(up), .count_dn_pin(dn),
		.manual_reset_pin(mr), .out1(out1), .out2(out2));
	cspoc_relay_model u_cspoc_relay_model (.mclk(mclk), .count_up_pin(up),
		.count_dn_pin(dn), .manual_reset_pin(mr));

	task automatic give_verdict();
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// classic cycle: request held until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rdchk(input string n, input logic [7:0] a,
			input logic [31:0] e);
		wb_xfer(1'b0, a, 32'h0);
		check(n, rd, e);
	endtask

	task automatic outs(input logic e1, e2);
		check("out1", {31'h0, out1}, {31'h0, e1});
		check("out2", {31'h0, out2}, {31'h0, e2});
	endtask

	task automatic setup(input logic [3:0] f,
			input logic [31:0] s1, s2, off, p1, p2);
		wb_xfer(1'b1, cspoc_pkg::OFS_FUNC, {28'h0, f});
		wb_xfer(1'b1, cspoc_pkg::OFS_FIRST_SETPOINT, s1);
		wb_xfer(1'b1, cspoc_pkg::OFS_SECOND_SETPOINT, s2);
		wb_xfer(1'b1, cspoc_pkg::OFS_OFFSET, off);
		wb_xfer(1'b1, cspoc_pkg::OFS_PULSE1, p1);
		wb_xfer(1'b1, cspoc_pkg::OFS_PULSE2, p2);
		u_cspoc_relay_model.press_reset();
	endtask

	task automatic t_reset();
		rdchk("func", cspoc_pkg::OFS_FUNC, 32'h1);
		rdchk("count", cspoc_pkg::OFS_COUNT, 32'h0);
		rdchk("status", cspoc_pkg::OFS_STATUS, 32'h4);
		rdchk("unmapped", 8'h24, 32'h0);
		// count is read-only: a write must leave it alone
		wb_xfer(1'b1, cspoc_pkg::OFS_COUNT, 32'h55);
		rdchk("count ro", cspoc_pkg::OFS_COUNT, 32'h0);
		outs(1'b0, 1'b0);
	endtask

	task automatic t_manual4();
		u_cspoc_relay_model.gap = 9;
		setup(cspoc_pkg::F_MR4, 32'h3, 32'h5, 32'h2, 32'h1, 32'h1);
		rdchk("count", cspoc_pkg::OFS_COUNT, 32'h2);
		u_cspoc_relay_model.step(1'b1, 1);
		outs(1'b1, 1'b0);
		u_cspoc_relay_model.step(1'b1, 3);
		outs(1'b1, 1'b1);
		rdchk("count", cspoc_pkg::OFS_COUNT, 32'h6);
		u_cspoc_relay_model.press_reset();
		rdchk("count", cspoc_pkg::OFS_COUNT, 32'h2);
		outs(1'b0, 1'b0);
		u_cspoc_relay_model.gap = 4;
	endtask

	task automatic t_manual5();
		setup(cspoc_pkg::F_MR5, 32'h2, 32'h4, 32'h0, 32'h0, 32'h0);
		u_cspoc_relay_model.step(1'b1, 4);
		outs(1'b1, 1'b1);
		u_cspoc_relay_model.step(1'b0, 3);
		outs(1'b1, 1'b1);
		u_cspoc_relay_model.step(1'b0, 1);
		outs(1'b0, 1'b0);
	endtask

	task automatic t_latch();
		for (int f = 6; f <= 7; f++) begin
			setup(f[3:0], 32'h2, 32'h4, 32'h0, 32'h0, 32'h0);
			u_cspoc_relay_model.step(1'b1, 5);
			outs(1'b1, 1'b1);
			rdchk("count", cspoc_pkg::OFS_COUNT, 32'h5);
		end
	endtask

	// per auto function: count right after the second setpoint, after one
	// more step, and the displayed value then
	task automatic t_auto();
		logic [31:0] c1 [7] = '{0, 3, 3, 3, 0, 3, 3};
		logic [31:0] c2 [7] = '{1, 4, 3, 3, 1, 4, 4};
		logic [31:0] dv [7] = '{1, 4, 3, 3, 3, 3, 4};
		for (int i = 0; i < 7; i++) begin
			setup(cspoc_pkg::F_AR_CLR + i[3:0], 32'h2, 32'h3, 32'h0, 32'h0,
				32'h0);
			u_cspoc_relay_model.step(1'b1, 3);
			outs(1'b1, 1'b1);
			rdchk("count hit", cspoc_pkg::OFS_COUNT, c1[i]);
			u_cspoc_relay_model.step(1'b1, 1);
			rdchk("count next", cspoc_pkg::OFS_COUNT, c2[i]);
			rdchk("display", cspoc_pkg::OFS_DISPLAY, dv[i]);
		end
	endtask

	// pulse ends: output 1 drops alone first for the stopping function only, otherwise output 2 takes it along
	task automatic t_pulse();
		logic [3:0]  fn [4] = '{cspoc_pkg::F_AR_STP, cspoc_pkg::F_AR_STRL,
			cspoc_pkg::F_AR_DHC, cspoc_pkg::F_AR_CPZ};
		logic [31:0] ce [4] = '{0, 3, 0, 0};
		for (int i = 0; i < 4; i++) begin
			setup(fn[i], 32'h2, 32'h3, 32'h0, (i == 0) ? 32'h3 : 32'h0,
				32'h8);
			u_cspoc_relay_model.step(1'b1, 2);
			outs(1'b1, 1'b0);
			if (i == 0) begin
				repeat (4 * TICK_T) @(posedge mclk);
				outs(1'b0, 1'b0);
			end
			u_cspoc_relay_model.step(1'b1, 1);
			outs(i != 0, 1'b1);
			rdchk("display held", cspoc_pkg::OFS_DISPLAY, 32'h3);
			repeat (10 * TICK_T) @(posedge mclk);
			outs(1'b0, 1'b0);
			rdchk("count end", cspoc_pkg::OFS_COUNT, ce[i]);
			rdchk("status end", cspoc_pkg::OFS_STATUS, 32'h4);
			rdchk("display end", cspoc_pkg::OFS_DISPLAY, ce[i]);
		end
	endtask

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// whole run is under two thousand cycles; this ceiling only cuts a hang
	always @(posedge mclk) begin
		cyc_count++;
		if (cyc_count == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	initial begin
		rst_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_manual4();
		t_manual5();
		t_latch();
		t_auto();
		t_pulse();
		give_verdict();
	end
endmodule // tb
